/* hdl/average_window_size_regs.svh */
/*
 * Register offsets, field positions, reset values and counts
 * for the proximity filter and emitter drive block.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef AVERAGE_WINDOW_SIZE_REGS_SVH
`define AVERAGE_WINDOW_SIZE_REGS_SVH

`define PF_ADDR_XTALK_CFG   8'hB8
`define PF_ADDR_DRIVE_CFG   8'hB9
`define PF_ADDR_HALVE_CFG   8'hBB
`define PF_ADDR_IRQ_STATUS  8'hE0
`define PF_ADDR_IRQ_MASK    8'hE1
`define PF_ADDR_XTALK_CTRL  8'hE2

`define PF_RST_XTALK_CFG    8'h00
`define PF_RST_DRIVE_CFG    8'h00
`define PF_RST_HALVE        1'h0
`define PF_RST_IRQ          2'h0
`define PF_RST_XTALK_A      1'h0

`define PF_BIT_XTALK_B      7
`define PF_BIT_DECIMATE     2
`define PF_FLD_WIN_HI       1
`define PF_FLD_WIN_LO       0
`define PF_FLD_CODE_HI      6
`define PF_FLD_CODE_LO      0
`define PF_BIT_HALVE        3
`define PF_BIT_XTALK_A      0

`define PF_IRQ_EVAL         0
`define PF_IRQ_XTALK        1

`define PF_SAMPLE_W         14
`define PF_NARROW_W         10
`define PF_SUM_W            17
`define PF_HIST_DEPTH       8
`define PF_NARROW_SHIFT     4
`define PF_DRIVE_BASE       9'h004

`endif

/* hdl/average_window_size_pkg.sv */
/*
 * Shared types for the proximity filter block.
 * Assumes the register header sits beside it in hdl/.
 */
`include "average_window_size_regs.svh"

package average_window_size_pkg;
  typedef logic [`PF_SAMPLE_W-1:0] prox_sample_t;
  typedef logic [1:0]              win_sel_t;
  typedef logic [6:0]              drive_code_t;
  typedef logic [8:0]              drive_ma_t;
endpackage : average_window_size_pkg

/* hdl/prox_avg_window.sv */
/*
 * Moving-average window with optional decimation of the result strobe.
 * Assumes samples arrive on core_clk and flush comes from the same domain.
 */
`timescale 1ns/100ps
`include "average_window_size_regs.svh"

module prox_avg_window (
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  input  wire logic                         clk_en,
  input  wire logic                         flush,
  input  wire logic                         sample_valid,
  input  wire average_window_size_pkg::prox_sample_t sample_data,
  input  wire average_window_size_pkg::win_sel_t    win_sel,
  input  wire logic                         decimate,
  output average_window_size_pkg::prox_sample_t     avg_q,
  output logic                              avg_valid_q
);
  import average_window_size_pkg::*;

  prox_sample_t            hist_q [`PF_HIST_DEPTH];
  logic [`PF_SUM_W-1:0]    sum_q;
  logic [2:0]              dcnt_q;

  wire  [2:0]              win_last  = 3'((4'h1 << win_sel) - 4'h1);
  wire  prox_sample_t      oldest    = hist_q[win_last];
  wire  [`PF_SUM_W-1:0]    sum_d     = sum_q + {3'h0, sample_data}
                                       - {3'h0, oldest};
  wire  [`PF_SUM_W-1:0]    sum_shift = sum_d >> win_sel;
  // RQ4 decimated or every sample
  wire                     dec_hit   = !decimate || (dcnt_q == win_last);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `PF_HIST_DEPTH; i++) begin
        hist_q[i] <= '0;
      end
      sum_q       <= '0;
      dcnt_q      <= 3'h0;
      avg_q       <= '0;
      avg_valid_q <= 1'b0;
    end else if (clk_en) begin
      avg_valid_q <= 1'b0;
      if (flush) begin
        for (int i = 0; i < `PF_HIST_DEPTH; i++) begin
          hist_q[i] <= '0;
        end
        sum_q  <= '0;
        dcnt_q <= 3'h0;
      end else if (sample_valid) begin
        // RQ3 window of 1,2,4,8
        hist_q[0] <= sample_data;
        for (int i = 1; i < `PF_HIST_DEPTH; i++) begin
          hist_q[i] <= hist_q[i-1];
        end
        sum_q  <= sum_d;
        dcnt_q <= dec_hit ? 3'h0 : dcnt_q + 3'h1;
        // RQ5 strobe rate for checks
        if (dec_hit) begin
          avg_q       <= sum_shift[`PF_SAMPLE_W-1:0];
          avg_valid_q <= 1'b1;
        end
      end
    end
  end
endmodule : prox_avg_window

/* hdl/average_window_size_led_drive_config.sv */
/*
 * Proximity result filter, high-crosstalk format and emitter drive config.
 * Assumes raw samples and register strobes come from core_clk logic.
 */
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
`include "average_window_size_regs.svh"

// Overview of operation
// (RQ1) In high-crosstalk operation results are given in a 10-bit format.
// (RQ2) That format is entered only when both crosstalk enable bits are set.
// (RQ3) Results are averaged over a window of 1, 2, 4 or 8 samples by code.
// (RQ4) Without decimation every average is used, with it one per window.
// (RQ5) The decimation bit at bit 2 sets how often checks see the average.
// (RQ6) Emitter drive current is twice the 7-bit code plus four milliamps.
// (RQ7) The halving bit divides the selected drive current by two.
// (RQ8) The halving bit is read/write at bit 3 of its register, reset zero.
// (RQ9) With only one crosstalk enable bit set the normal format is kept.
module average_window_size_led_drive_config (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [7:0]                         reg_rdata_q,
  input  wire logic                          sample_valid,
  input  wire average_window_size_pkg::prox_sample_t sample_data,
  output average_window_size_pkg::prox_sample_t      result_q,
  output logic                               result_check_q,
  output logic                               narrow_mode_q,
  output average_window_size_pkg::drive_ma_t         emitter_ma_q,
  output logic                               irq_q
);
  import average_window_size_pkg::*;

  logic [7:0]   xtalk_cfg_q;
  logic [6:0]   drive_cfg_q;
  logic         halve_q;
  logic         xtalk_a_q;
  logic [1:0]   status_q;
  logic [1:0]   mask_q;
  prox_sample_t avg;
  logic         avg_valid;

  // Address decode
  wire wr_xtalk  = reg_wr && (reg_addr == `PF_ADDR_XTALK_CFG);
  wire wr_drive  = reg_wr && (reg_addr == `PF_ADDR_DRIVE_CFG);
  wire wr_halve  = reg_wr && (reg_addr == `PF_ADDR_HALVE_CFG);
  wire wr_status = reg_wr && (reg_addr == `PF_ADDR_IRQ_STATUS);
  wire wr_mask   = reg_wr && (reg_addr == `PF_ADDR_IRQ_MASK);
  wire wr_ctrl   = reg_wr && (reg_addr == `PF_ADDR_XTALK_CTRL);

  // Fields
  wire      xtalk_b   = xtalk_cfg_q[`PF_BIT_XTALK_B];
  wire      decimate  = xtalk_cfg_q[`PF_BIT_DECIMATE];
  win_sel_t win_sel;
  assign    win_sel   = xtalk_cfg_q[`PF_FLD_WIN_HI:`PF_FLD_WIN_LO];

  // RQ2 both enables needed
  // RQ9 single enable keeps normal
  wire narrow_d = xtalk_a_q && xtalk_b;

  // RQ1 10-bit result format
  wire [`PF_SAMPLE_W-1:0] avg_narrow = avg >> `PF_NARROW_SHIFT;
  prox_sample_t           result_d;
  assign result_d = narrow_d
                  ? {{(`PF_SAMPLE_W-`PF_NARROW_W){1'b0}},
                     avg_narrow[`PF_NARROW_W-1:0]}
                  : avg;

  // RQ6 code times two plus four
  wire [8:0] full_ma = {1'b0, drive_cfg_q, 1'b0} + `PF_DRIVE_BASE;
  // RQ7 halve selected current
  wire [8:0] drive_d = halve_q ? {1'b0, full_ma[8:1]} : full_ma;

  // Events, set wins over clear
  wire [1:0] event_set;
  assign event_set[`PF_IRQ_EVAL]  = avg_valid;
  assign event_set[`PF_IRQ_XTALK] = narrow_d && !narrow_mode_q;
  wire [1:0] clr_bits  = wr_status ? reg_wdata[1:0] : 2'h0;
  wire [1:0] status_d  = (status_q & ~clr_bits) | event_set;

  // Read mux
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      `PF_ADDR_XTALK_CFG:  rd_mux = xtalk_cfg_q;
      `PF_ADDR_DRIVE_CFG:  rd_mux = {1'b0, drive_cfg_q};
      `PF_ADDR_HALVE_CFG:  rd_mux = {4'h0, halve_q, 3'h0};
      `PF_ADDR_IRQ_STATUS: rd_mux = {6'h00, status_q};
      `PF_ADDR_IRQ_MASK:   rd_mux = {6'h00, mask_q};
      `PF_ADDR_XTALK_CTRL: rd_mux = {7'h00, xtalk_a_q};
      default:             rd_mux = 8'h00;
    endcase
  end

  // Configuration registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      xtalk_cfg_q <= `PF_RST_XTALK_CFG;
      drive_cfg_q <= 7'(`PF_RST_DRIVE_CFG);
      halve_q     <= `PF_RST_HALVE;
      xtalk_a_q   <= `PF_RST_XTALK_A;
      mask_q      <= `PF_RST_IRQ;
    end else if (clk_en) begin
      if (wr_xtalk) begin
        xtalk_cfg_q <= reg_wdata & 8'h87;
      end
      if (wr_drive) begin
        drive_cfg_q <= reg_wdata[`PF_FLD_CODE_HI:`PF_FLD_CODE_LO];
      end
      // RQ8 halving bit storage
      if (wr_halve) begin
        halve_q <= reg_wdata[`PF_BIT_HALVE];
      end
      if (wr_ctrl) begin
        xtalk_a_q <= reg_wdata[`PF_BIT_XTALK_A];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[1:0];
      end
    end
  end

  // Status, read data and outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_q       <= `PF_RST_IRQ;
      reg_rdata_q    <= 8'h00;
      result_q       <= '0;
      result_check_q <= 1'b0;
      narrow_mode_q  <= 1'b0;
      emitter_ma_q   <= `PF_DRIVE_BASE;
      irq_q          <= 1'b0;
    end else if (clk_en) begin
      status_q       <= status_d;
      reg_rdata_q    <= reg_rd ? rd_mux : 8'h00;
      narrow_mode_q  <= narrow_d;
      emitter_ma_q   <= drive_d;
      irq_q          <= |(status_d & mask_q);
      // RQ4 result used for checks
      result_check_q <= avg_valid;
      if (avg_valid) begin
        result_q <= result_d;
      end
    end
  end

  // RQ3 averaging window
  prox_avg_window u_avg (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .clk_en       (clk_en),
    .flush        (wr_xtalk),
    .sample_valid (sample_valid),
    .sample_data  (sample_data),
    .win_sel      (win_sel),
    .decimate     (decimate),
    .avg_q        (avg),
    .avg_valid_q  (avg_valid)
  );
endmodule : average_window_size_led_drive_config

/* testbench/average_window_size_props.sv */
/* Checker for the proximity filter block.
   Assumes binding onto the top module, one clock domain. */
`timescale 1ns/100ps
module average_window_size_props (
  input wire logic                          core_clk,
  input wire logic                          resetn,
  input wire logic                          clk_en,
  input wire logic [7:0]                    reg_addr,
  input wire logic [7:0]                    reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [7:0]                    reg_rdata_q,
  input wire logic                          sample_valid,
  input wire average_window_size_pkg::prox_sample_t sample_data,
  input wire average_window_size_pkg::prox_sample_t result_q,
  input wire logic                          result_check_q,
  input wire logic                          narrow_mode_q,
  input wire average_window_size_pkg::drive_ma_t    emitter_ma_q,
  input wire logic                          irq_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata_q == 0)
    else $error("read data outside read slot");
  a_check_from_sample: assert property (result_check_q && $past(clk_en)
    && $past(clk_en, 2) |-> $past(sample_valid, 2))
    else $error("check strobe without sample");
  a_result_holds: assert property (
    !result_check_q |-> $stable(result_q))
    else $error("result changed without check");
  a_narrow_top_zero: assert property (result_check_q && narrow_mode_q
    && $past(narrow_mode_q) |-> result_q[13:10] == 0)
    else $error("narrow result too wide");
  a_drive_after_wr: assert property ($changed(emitter_ma_q) |->
    $past(reg_wr, 2))
    else $error("drive changed without write");
  a_drive_reset_val: assert property (
    $rose(resetn) |-> emitter_ma_q == 4)
    else $error("drive reset value wrong");
  a_narrow_after_wr: assert property ($changed(narrow_mode_q) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("format changed without write");
  a_irq_fall_cause: assert property ($fell(irq_q) |->
    $past(reg_wr) || $past(reg_wr, 2))
    else $error("irq fell without write");
  a_frozen_state: assert property (!$past(clk_en) |-> $stable(result_q)
    && $stable(emitter_ma_q))
    else $error("state moved while frozen");
endmodule : average_window_size_props
bind average_window_size_led_drive_config average_window_size_props chk_u (.*);

/* testbench/emitter_model.sv */
/* Emitter model: draws the commanded current one cycle later.
   Assumes the drive code lives on core_clk. */
`timescale 1ns/100ps
module emitter_model (
  input  wire logic                       core_clk,
  input  wire average_window_size_pkg::drive_ma_t emitter_ma_q,
  output average_window_size_pkg::drive_ma_t      drawn_ma
);
  always_ff @(posedge core_clk) begin
    drawn_ma <= emitter_ma_q;
  end
endmodule : emitter_model

/* testbench/average_window_size_led_drive_config_tb_top.sv */
/* Testbench: register, filter, format, drive and irq sequences.
   Assumes the block and the emitter model compiled before it. */
`timescale 1ns/100ps
module average_window_size_led_drive_config_tb_top;
  import average_window_size_pkg::*;
  logic core_clk, resetn, clk_en, reg_wr, reg_rd, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  prox_sample_t sample_data, result_q, last_res;
  logic result_check_q, narrow_mode_q, irq_q;
  drive_ma_t emitter_ma_q, drawn_ma;
  int num_errors = 0, n_checks = 0, n;
  average_window_size_led_drive_config dut_u (.core_clk(core_clk), .resetn(resetn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .result_q(result_q), .result_check_q(result_check_q),
    .narrow_mode_q(narrow_mode_q), .emitter_ma_q(emitter_ma_q),
    .irq_q(irq_q));
  emitter_model em_u (.core_clk(core_clk), .emitter_ma_q(emitter_ma_q),
    .drawn_ma(drawn_ma));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 chk(reg_rdata_q, exp);
  endtask : rd
  task settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle
  task smp(input prox_sample_t v, input logic ec, input prox_sample_t er);
    @(posedge core_clk);
    sample_valid <= 1; sample_data <= v;
    @(posedge core_clk);
    sample_valid <= 0;
    @(posedge core_clk);
    #1 chk(result_check_q, ec);
    chk(result_q, er);
  endtask : smp
  task close_out;
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    num_errors++;
    close_out();
  end
  initial begin
    resetn = 0; clk_en = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0;
    reg_wdata = 0; sample_valid = 0; sample_data = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    rd(8'hB8, 0); rd(8'hB9, 0); rd(8'hBB, 0); rd(8'h10, 0);
    chk(emitter_ma_q, 4);
    wr(8'hB8, 8'hFF); rd(8'hB8, 8'h87);
    wr(8'hBB, 8'hFF); rd(8'hBB, 8'h08);
    for (int i = 0; i < 8; i++) begin
      n = (i[0]) ? 126 + i[1] : i[1];
      wr(8'hB9, n[7:0] | 8'h80); wr(8'hBB, {4'h0, i[2], 3'h0});
      settle();
      chk(emitter_ma_q, i[2] ? n + 2 : 2 * n + 4);
      chk(drawn_ma, i[2] ? n + 2 : 2 * n + 4);
      rd(8'hB9, n[7:0] & 8'h7F);
    end
    last_res = 0;
    for (int c = 0; c < 8; c++) begin
      wr(8'hB8, c[2:0]);
      for (int k = 1; k <= (1 << c[1:0]); k++) begin
        if (!c[2] || k == (1 << c[1:0])) last_res = (k * 14'h1234) >> c[1:0];
        smp(14'h1234, !c[2] || k == (1 << c[1:0]), last_res);
      end
    end
    wr(8'hE1, 0); wr(8'hE0, 8'hFF); settle(); chk(irq_q, 0);
    wr(8'hE2, 1); settle(); chk(narrow_mode_q, 0);
    wr(8'hB8, 0); wr(8'hE2, 0); wr(8'hB8, 8'h80); settle();
    chk(narrow_mode_q, 0);
    wr(8'hE2, 1); settle(); chk(narrow_mode_q, 1);
    rd(8'hE2, 8'h01);
    smp(14'h3FF7, 1, 14'h03FF);
    rd(8'hE0, 8'h03); chk(irq_q, 0);
    wr(8'hE1, 8'h01); settle(); chk(irq_q, 1);
    rd(8'hE1, 8'h01);
    wr(8'hE0, 8'h01); settle(); chk(irq_q, 0);
    @(posedge core_clk);
    clk_en <= 0;
    smp(14'h0100, 0, 14'h03FF);
    @(posedge core_clk);
    clk_en <= 1;
    wr(8'hE2, 0); settle(); chk(narrow_mode_q, 0);
    close_out();
  end
endmodule : average_window_size_led_drive_config_tb_top
